// ===== hdl/emc_map_if.sv
// request to address-translation link inside the memory controller
// assumes the translation is purely combinational
`timescale 1ns/10ps
interface emc_map_if;
    import emc_pkg::*;
    emc_space_e               space;
    logic [ADDR_W-1:0]        addr;
    logic [NSEC-1:0]          overlay_en;
    logic [TOP_W-1:0]         top_sec;
    logic                     to_data_cs;
    logic [ADDR_W-1:0]        phys;
    logic                     refused;

    modport req (output space, addr, overlay_en, top_sec, input to_data_cs, phys, refused);
    modport map (input space, addr, overlay_en, top_sec, output to_data_cs, phys, refused);
endinterface

// ===== hdl/emc_overlay_map.sv
// code-space overlay translation and chip select choice
// assumes the requester holds its inputs stable while it samples the results
`timescale 1ns/10ps
module emc_overlay_map (
    emc_map_if.map m
);
    import emc_pkg::*;

    logic [SEC_W-1:0] sec;
    logic             ovl;

    always_comb begin
        sec          = m.addr[SEC_LSB +: SEC_W];
        ovl          = m.overlay_en[sec];
        m.to_data_cs = 1'b1;
        m.phys       = m.addr;
        m.refused    = 1'b0;
        if (m.space != EMC_SP_DATA) begin
            // internal rom is not visible through the data window
            m.refused = (m.space == EMC_SP_CODE_AS_DATA) && (m.addr < ROM_LIMIT);
            if (ovl) begin
                // top code section lands on the top ram section, lower ones grow down
                m.phys = {TOP_W'(m.top_sec - TOP_W'(NSEC - 1 - int'(sec))),
                          m.addr[SEC_LSB-1:0]};
            end else begin
                m.to_data_cs = 1'b0;
                m.phys       = {{(ADDR_W-SEC_LSB-SEC_W){1'b0}}, m.addr[SEC_LSB+SEC_W-1:0]};
            end
        end
    end
endmodule // emc_overlay_map

// ===== hdl/emc_pin_sync.sv
// data bus input synchroniser and reset-time strap capture
// assumes the data pins are asynchronous to ref_clk
`timescale 1ns/10ps
module emc_pin_sync (
    input  wire logic                       ref_clk,
    input  wire logic                       resetn,
    input  wire logic [emc_pkg::DATA_W-1:0] mem_data_i,
    output logic      [emc_pkg::DATA_W-1:0] data_sync,
    output logic                            strap_single16
);
    import emc_pkg::*;

    logic [DATA_W-1:0] meta_r;
    logic [DATA_W-1:0] sync_r;
    logic              memory_data_strap_r;
    logic              memory_data_strap_nxt;

    // strap follows the pin while reset is held and freezes at release
    always_comb begin
        memory_data_strap_nxt = memory_data_strap_r;
        if (!resetn) begin
            memory_data_strap_nxt = sync_r[STRAP_BIT];
        end
    end

    // no reset on the synchroniser so the strap sees the live pin during reset
    always_ff @(posedge ref_clk) begin
        meta_r              <= mem_data_i;
        sync_r              <= meta_r;
        memory_data_strap_r <= memory_data_strap_nxt;
    end

    assign data_sync      = sync_r;
    assign strap_single16 = memory_data_strap_r;
endmodule // emc_pin_sync

// ===== hdl/emc_pkg.sv
// constants and types shared by the external memory controller files
// assumes one 200 MHz clock and a synchronous active-low reset
package emc_pkg;
    localparam int ADDR_W        = 22;           // 4 Mbyte byte space
    localparam int DATA_W        = 16;
    localparam int SEC_LSB       = 14;           // 16 kbyte overlay sections
    localparam int SEC_W         = 3;            // 8 sections span the 128 kbyte code range
    localparam int NSEC          = 8;
    localparam int TOP_W         = 8;            // section number within the 4 Mbyte space
    localparam int CNT_W         = 8;
    localparam int STRAP_BIT     = 0;            // data bus bit sampled during reset
    localparam logic [ADDR_W-1:0] ROM_LIMIT = 22'h001000;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int HOLD_NS       = 20;
    localparam int STROBE_NS     = 40;
    localparam int SLOW_MULT     = 4;
    localparam int HOLD_CYC      = (HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_CYC    = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SLOW_CYC      = STROBE_CYC * SLOW_MULT;

    typedef enum logic [1:0] {
        EMC_SP_CODE,
        EMC_SP_DATA,
        EMC_SP_CODE_AS_DATA
    } emc_space_e;

    typedef enum logic [1:0] {
        EMC_ORG_X8,
        EMC_ORG_TWO_X8,
        EMC_ORG_X16
    } emc_org_e;

    typedef enum logic [1:0] {
        EMC_ST_IDLE,
        EMC_ST_SETUP,
        EMC_ST_STROBE,
        EMC_ST_HOLD
    } emc_state_e;
endpackage

// ===== hdl/emc_top.sv
// external memory controller: code and data chip selects, overlay, 8/16-bit pin modes
// assumes the requester holds req and its fields until ack, and config is quasi-static
//
// Functional notes
// - One chip select serves code space and a separate one serves data space.
// - Up to four megabytes of external memory are addressed.
// - RAM can overlay code space in 16 kbyte sections, top of memory downward, up to 128 kbyte.
// - Code space reads as data through the overlay, except the internal rom, which is refused.
// - Strobes run slow or at the normal rate as fast_rate stands when each access starts, the first after reset included.
// - Code space and data space each are 8 or 16 bits wide, independently.
// - Whether a 16-bit data space is one x16 part or two x8 parts comes from a data bus strap caught during reset.
// - An 8-bit access drives the shared pin as address bit 0, one write strobe, oe for reads.
// - A 16-bit space of two x8 parts uses the shared pin as high write and the low strobe as low write.
// - A single x16 part uses the shared pin and the low enable pin as byte enables, one write strobe.
// - Pin functions follow the accessed space on every cycle, with no outside logic.
`timescale 1ns/10ps
module emc_top (
    input  wire logic                       ref_clk,
    input  wire logic                       resetn,
    input  wire logic                       req,
    input  wire emc_pkg::emc_space_e        req_space,
    input  wire logic                       req_we,
    input  wire logic [emc_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [1:0]                 req_be,
    input  wire logic [emc_pkg::DATA_W-1:0] req_wdata,
    output logic                            ack,
    output logic                            err,
    output logic      [emc_pkg::DATA_W-1:0] rdata,
    input  wire logic                       code_wide16,
    input  wire logic                       data_wide16,
    input  wire logic                       code_single16,
    input  wire logic                       fast_rate,
    input  wire logic [emc_pkg::NSEC-1:0]   overlay_en,
    input  wire logic [emc_pkg::TOP_W-1:0]  data_top_sec,
    output logic                            code_cs_n,
    output logic                            data_cs_n,
    output logic      [emc_pkg::ADDR_W-1:1] mem_addr,
    output logic                            addr_lsb_or_high_byte_strobe,
    output logic                            low_write_strobe_n,
    output logic                            read_output_enable_n,
    output logic                            low_byte_enable_pin_n,
    output logic      [emc_pkg::DATA_W-1:0] mem_data_o,
    output logic                            mem_data_oe,
    input  wire logic [emc_pkg::DATA_W-1:0] mem_data_i
);
    import emc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    emc_state_e        st_r,     st_nxt;
    emc_org_e          org_r,    org_nxt;
    logic [CNT_W-1:0]  cnt_r,    cnt_nxt;
    logic              ack_r,    ack_nxt;
    logic              err_r,    err_nxt;
    logic [DATA_W-1:0] rdata_r,  rdata_nxt;
    logic              ccs_n_r,  ccs_n_nxt;
    logic              dcs_n_r,  dcs_n_nxt;
    logic [ADDR_W-1:1] addr_r,   addr_nxt;
    logic              shared_r, shared_nxt;
    logic              we_n_r,   we_n_nxt;
    logic              oe_n_r,   oe_n_nxt;
    logic              lbe_n_r,  lbe_n_nxt;
    logic [DATA_W-1:0] dout_r,   dout_nxt;
    logic              doe_r,    doe_nxt;
    logic              we_r,     we_nxt;
    logic [1:0]        be_r,     be_nxt;
    logic [DATA_W-1:0] wdata_r,  wdata_nxt;
    logic              hi_r,     hi_nxt;
    logic              fast_r,   fast_nxt;
    logic [DATA_W-1:0] data_sync;
    logic              strap_single16;
    logic              take;

    emc_map_if mif ();

    assign mif.space      = req_space;
    assign mif.addr       = req_addr;
    assign mif.overlay_en = overlay_en;
    assign mif.top_sec    = data_top_sec;

    emc_overlay_map u_map (
        .m (mif)
    );

    emc_pin_sync u_sync (
        .ref_clk        (ref_clk),
        .resetn         (resetn),
        .mem_data_i     (mem_data_i),
        .data_sync      (data_sync),
        .strap_single16 (strap_single16)
    );

    ////////////////////////////////////////////////////////////////////////////
    // organisation of whichever space the access lands in; one per space
    function automatic emc_org_e org_of(input logic to_data, input logic cw, input logic dw,
                                        input logic cs16, input logic ds16);
        logic wide;
        logic single;
        wide   = to_data ? dw : cw;
        single = to_data ? ds16 : cs16;
        if (!wide) begin
            org_of = EMC_ORG_X8;
        end else if (single) begin
            org_of = EMC_ORG_X16;
        end else begin
            org_of = EMC_ORG_TWO_X8;
        end
    endfunction

    // idle level of the shared pin during setup and hold
    function automatic logic shared_idle(input emc_org_e org, input logic hi, input logic [1:0] be);
        case (org)
            EMC_ORG_X8:  shared_idle = hi;     // address bit 0
            EMC_ORG_X16: shared_idle = !be[1]; // upper byte enable
            default:     shared_idle = 1'b1;   // high write strobe parked
        endcase
    endfunction

    function automatic logic [DATA_W-1:0] lane_out(input emc_org_e org, input logic hi,
                                                   input logic [DATA_W-1:0] wd);
        if (org == EMC_ORG_X8) begin
            lane_out = {8'h00, hi ? wd[15:8] : wd[7:0]};
        end else begin
            lane_out = wd;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign take = req && !ack_r && !err_r;

    always_comb begin
        st_nxt     = st_r;
        org_nxt    = org_r;
        cnt_nxt    = cnt_r;
        ack_nxt    = 1'b0;
        err_nxt    = 1'b0;
        rdata_nxt  = rdata_r;
        ccs_n_nxt  = ccs_n_r;
        dcs_n_nxt  = dcs_n_r;
        addr_nxt   = addr_r;
        shared_nxt = shared_r;
        we_n_nxt   = we_n_r;
        oe_n_nxt   = oe_n_r;
        lbe_n_nxt  = lbe_n_r;
        dout_nxt   = dout_r;
        doe_nxt    = doe_r;
        we_nxt     = we_r;
        be_nxt     = be_r;
        wdata_nxt  = wdata_r;
        hi_nxt     = hi_r;
        fast_nxt   = fast_r;
        case (st_r)
            EMC_ST_IDLE: begin
                if (take && mif.refused) begin
                    err_nxt = 1'b1;
                    ack_nxt = 1'b1;
                end else if (take) begin
                    // cs and address go out a cycle ahead of any strobe
                    org_nxt    = org_of(mif.to_data_cs, code_wide16, data_wide16,
                                        code_single16, strap_single16);
                    ccs_n_nxt  = mif.to_data_cs;
                    dcs_n_nxt  = !mif.to_data_cs;
                    addr_nxt   = mif.phys[ADDR_W-1:1];
                    hi_nxt     = (org_nxt == EMC_ORG_X8) && (mif.phys[0] || req_be == 2'b10);
                    shared_nxt = shared_idle(org_nxt, hi_nxt, req_be);
                    lbe_n_nxt  = !((org_nxt == EMC_ORG_X16) && req_be[0]);
                    dout_nxt   = lane_out(org_nxt, hi_nxt, req_wdata);
                    doe_nxt    = req_we;
                    we_nxt     = req_we;
                    be_nxt     = req_be;
                    wdata_nxt  = req_wdata;
                    rdata_nxt  = '0;
                    fast_nxt   = fast_rate;
                    st_nxt     = EMC_ST_SETUP;
                end
            end
            EMC_ST_SETUP: begin
                cnt_nxt = fast_r ? CNT_W'(STROBE_CYC - 1) : CNT_W'(SLOW_CYC - 1);
                st_nxt  = EMC_ST_STROBE;
                if (!we_r) begin
                    oe_n_nxt = 1'b0;
                end else if (org_r == EMC_ORG_TWO_X8) begin
                    we_n_nxt   = !be_r[0];
                    shared_nxt = !be_r[1];
                end else begin
                    we_n_nxt = 1'b0;
                end
            end
            EMC_ST_STROBE: begin
                if (cnt_r == '0) begin
                    oe_n_nxt   = 1'b1;
                    we_n_nxt   = 1'b1;
                    shared_nxt = shared_idle(org_r, hi_r, be_r);
                    cnt_nxt    = CNT_W'(HOLD_CYC - 1);
                    st_nxt     = EMC_ST_HOLD;
                    // synchronised bus reflects the pins two cycles back, well inside the strobe
                    if (!we_r && org_r != EMC_ORG_X8) begin
                        rdata_nxt = data_sync;
                    end else if (!we_r && hi_r) begin
                        rdata_nxt[15:8] = data_sync[7:0];
                    end else if (!we_r) begin
                        rdata_nxt[7:0] = data_sync[7:0];
                    end
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            EMC_ST_HOLD: begin
                if (cnt_r != '0) begin
                    cnt_nxt = cnt_r - 1'b1;
                end else if (org_r == EMC_ORG_X8 && !hi_r && be_r == 2'b11) begin
                    // high byte of a word on an 8-bit space, chip select kept low
                    hi_nxt     = 1'b1;
                    shared_nxt = 1'b1;
                    dout_nxt   = lane_out(org_r, 1'b1, wdata_r);
                    st_nxt     = EMC_ST_SETUP;
                end else begin
                    ccs_n_nxt  = 1'b1;
                    dcs_n_nxt  = 1'b1;
                    lbe_n_nxt  = 1'b1;
                    shared_nxt = 1'b1;
                    doe_nxt    = 1'b0;
                    ack_nxt    = 1'b1;
                    st_nxt     = EMC_ST_IDLE;
                end
            end
            default: begin
                st_nxt = EMC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_r     <= EMC_ST_IDLE;
            org_r    <= EMC_ORG_X8;
            cnt_r    <= '0;
            ack_r    <= 1'b0;
            err_r    <= 1'b0;
            rdata_r  <= '0;
            ccs_n_r  <= 1'b1;
            dcs_n_r  <= 1'b1;
            addr_r   <= '0;
            shared_r <= 1'b1;
            we_n_r   <= 1'b1;
            oe_n_r   <= 1'b1;
            lbe_n_r  <= 1'b1;
            dout_r   <= '0;
            doe_r    <= 1'b0;
            we_r     <= 1'b0;
            be_r     <= '0;
            wdata_r  <= '0;
            hi_r     <= 1'b0;
            fast_r   <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            org_r    <= org_nxt;
            cnt_r    <= cnt_nxt;
            ack_r    <= ack_nxt;
            err_r    <= err_nxt;
            rdata_r  <= rdata_nxt;
            ccs_n_r  <= ccs_n_nxt;
            dcs_n_r  <= dcs_n_nxt;
            addr_r   <= addr_nxt;
            shared_r <= shared_nxt;
            we_n_r   <= we_n_nxt;
            oe_n_r   <= oe_n_nxt;
            lbe_n_r  <= lbe_n_nxt;
            dout_r   <= dout_nxt;
            doe_r    <= doe_nxt;
            we_r     <= we_nxt;
            be_r     <= be_nxt;
            wdata_r  <= wdata_nxt;
            hi_r     <= hi_nxt;
            fast_r   <= fast_nxt;
        end
    end

    assign ack                          = ack_r;
    assign err                          = err_r;
    assign rdata                        = rdata_r;
    assign code_cs_n                    = ccs_n_r;
    assign data_cs_n                    = dcs_n_r;
    assign mem_addr                     = addr_r;
    assign addr_lsb_or_high_byte_strobe = shared_r;
    assign low_write_strobe_n           = we_n_r;
    assign read_output_enable_n         = oe_n_r;
    assign low_byte_enable_pin_n        = lbe_n_r;
    assign mem_data_o                   = dout_r;
    assign mem_data_oe                  = doe_r;

    ////////////////////////////////////////////////////////////////////////////
    logic             cs_act;
    logic             strobe_act;
    logic [CNT_W-1:0] slen_r;
    logic [CNT_W-1:0] slen_nxt;

    assign cs_act     = !ccs_n_r || !dcs_n_r;
    assign strobe_act = !oe_n_r || !we_n_r || (org_r == EMC_ORG_TWO_X8 && !shared_r);
    assign slen_nxt   = strobe_act ? CNT_W'(slen_r + 1'b1) : '0;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            slen_r <= '0;
        end else begin
            slen_r <= slen_nxt;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_strobe_end;
        $fell(strobe_act);
    endsequence

    sequence s_cs_held;
        (cs_act && $stable(addr_r)) [*4];
    endsequence

    AST_ONE_CS: assert property (!(!ccs_n_r && !dcs_n_r))
        else $error("both chip selects active");
    AST_CS_LEADS: assert property ($rose(strobe_act) |-> $past(cs_act))
        else $error("strobe asserted without prior chip select");
    AST_ADDR_STABLE: assert property (strobe_act && $past(strobe_act) |-> $stable(addr_r))
        else $error("address moved under strobe");
    AST_CS_HOLD: assert property (s_strobe_end |-> s_cs_held)
        else $error("chip select or address released too early");
    AST_STROBE_LEN: assert property (s_strobe_end |-> slen_r == (fast_r ? CNT_W'(STROBE_CYC)
                                                                       : CNT_W'(SLOW_CYC)))
        else $error("strobe width does not match rate");
    AST_ROM_REFUSED: assert property (st_r == EMC_ST_IDLE && take && req_space == EMC_SP_CODE_AS_DATA
                                      && req_addr < ROM_LIMIT |=> err_r && ack_r && !cs_act)
        else $error("internal rom reachable as data");
    AST_OVERLAY_CS: assert property (st_r == EMC_ST_IDLE && take && req_space == EMC_SP_CODE
                                     && overlay_en[req_addr[SEC_LSB +: SEC_W]]
                                     |=> !dcs_n_r && ccs_n_r)
        else $error("overlaid code section not sent to data ram");
    AST_X8_LSB: assert property (org_r == EMC_ORG_X8 && cs_act |-> shared_r == hi_r && lbe_n_r)
        else $error("8-bit space shared pin not address bit 0");
    AST_TWO_X8_WEH: assert property (org_r == EMC_ORG_TWO_X8 && !shared_r
                                     |-> we_r && be_r[1] && st_r == EMC_ST_STROBE)
        else $error("high write strobe outside a high byte write");
    AST_X16_BE: assert property (org_r == EMC_ORG_X16 && cs_act && st_r != EMC_ST_IDLE
                                 |-> shared_r == !be_r[1] && lbe_n_r == !be_r[0])
        else $error("x16 byte enables do not follow request");
endmodule // emc_top

// ===== verification/emc_mem_model.sv
// behavioural external sram/flash for both chip selects of the memory controller
// assumes one chip select low at a time; strap level is driven while reset is low
`timescale 1ns/10ps
module emc_mem_model
    import emc_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                resetn,
    input  wire logic                strap,
    input  wire emc_org_e            code_org,
    input  wire emc_org_e            data_org,
    input  wire logic                code_cs_n,
    input  wire logic                data_cs_n,
    input  wire logic [ADDR_W-1:1]   mem_addr,
    input  wire logic                addr_lsb_or_high_byte_strobe,
    input  wire logic                low_write_strobe_n,
    input  wire logic                read_output_enable_n,
    input  wire logic                low_byte_enable_pin_n,
    input  wire logic [DATA_W-1:0]   mem_data_o,
    input  wire logic                mem_data_oe,
    output logic      [DATA_W-1:0]   mem_data_i
);
    logic [7:0]  mem [logic [22:0]];
    logic [15:0] last_r;
    logic [15:0] rd;
    logic [22:0] base;
    logic        sel;
    logic        hi_n;
    emc_org_e    org;

    function automatic logic [7:0] rbyte(input logic [22:0] a);
        return mem.exists(a) ? mem[a] : 8'h00;
    endfunction

    ////////////////////////////////////////////////////////////////
    always_comb begin
        sel  = !code_cs_n || !data_cs_n;
        hi_n = addr_lsb_or_high_byte_strobe;
        org  = !data_cs_n ? data_org : code_org;
        base = {!data_cs_n, mem_addr, (org == EMC_ORG_X8) ? hi_n : 1'b0};
        rd   = (org == EMC_ORG_X8) ? {~last_r[15:8], rbyte(base)} : {rbyte(base + 23'h1), rbyte(base)};
    end

    // released bus shows the inverse of the last value, not a stale copy
    assign mem_data_i = !resetn ? {15'h0000, strap} : (sel && !read_output_enable_n) ? rd : ~last_r;

    always @(posedge ref_clk) begin
        if (sel && !read_output_enable_n)
            last_r <= rd;
        // writes land only while the controller drives the data pins
        if (sel && mem_data_oe && org == EMC_ORG_X8 && !low_write_strobe_n)
            mem[base] = mem_data_o[7:0];
        if (sel && mem_data_oe && org == EMC_ORG_TWO_X8) begin
            if (!low_write_strobe_n) mem[base] = mem_data_o[7:0];
            if (!hi_n) mem[base + 23'h1] = mem_data_o[15:8];
        end
        if (sel && mem_data_oe && org == EMC_ORG_X16 && !low_write_strobe_n) begin
            if (!low_byte_enable_pin_n) mem[base] = mem_data_o[7:0];
            if (!hi_n) mem[base + 23'h1] = mem_data_o[15:8];
        end
    end
endmodule // emc_mem_model

// ===== verification/testbench.sv
// self-checking bench for the external memory controller with a memory model
// assumes fast x16 data ram after strap 1, x8 code flash unless told otherwise
`timescale 1ns/10ps
module testbench;
    import emc_pkg::*;
    logic ref_clk, resetn, req, req_we, ack, err, strap, mem_data_oe;
    logic code_wide16, data_wide16, code_single16, fast_rate, code_cs_n, data_cs_n;
    logic addr_lsb_or_high_byte_strobe, low_write_strobe_n, read_output_enable_n, low_byte_enable_pin_n;
    emc_space_e          req_space;
    emc_org_e            code_org, data_org;
    logic [ADDR_W-1:0]   req_addr;
    logic [ADDR_W-1:1]   mem_addr;
    logic [1:0]          req_be;
    logic [DATA_W-1:0]   req_wdata, rdata, mem_data_o, mem_data_i;
    logic [NSEC-1:0]     overlay_en;
    logic [TOP_W-1:0]    data_top_sec;
    int                  n_fail, num_checks;

    assign code_org = code_wide16 ? (code_single16 ? EMC_ORG_X16 : EMC_ORG_TWO_X8) : EMC_ORG_X8;
    assign data_org = data_wide16 ? (strap ? EMC_ORG_X16 : EMC_ORG_TWO_X8) : EMC_ORG_X8;
    emc_top u_dut (.*);
    emc_mem_model u_mem (.*);

    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (!ok) begin
            n_fail++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic do_reset(input logic s);
        strap = s;
        resetn = 1'b0;
        repeat (10) @(negedge ref_clk);
        resetn = 1'b1;
    endtask

    // exp_n of zero skips the latency check
    task automatic acc(input emc_space_e sp, input logic we, input logic [ADDR_W-1:0] a, input logic [1:0] be,
                       input logic [15:0] wd, input int exp_n, input logic exp_err, input logic [15:0] exp_rd);
        int n;
        @(negedge ref_clk);
        {req, req_we, req_addr, req_be, req_wdata} = {1'b1, we, a, be, wd};
        req_space = sp;
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
            if (sp == EMC_SP_DATA || exp_err) chk(code_cs_n === 1'b1, "code select during data access");
            if (exp_err) chk(data_cs_n === 1'b1, "data select on refused access");
        end while (ack !== 1'b1 && n < 200);
        req = 1'b0;
        chk(ack === 1'b1 && err === exp_err, "ack or err wrong");
        if (exp_n != 0) chk(n == exp_n, "ack latency wrong");
        if (!we && !exp_err) chk(rdata === exp_rd, "read data wrong");
    endtask

    ////////////////////////////////////////////////////////////////
    task automatic t_idle();
        chk({code_cs_n, data_cs_n, addr_lsb_or_high_byte_strobe} === 3'b111, "selects not idle");
        chk({low_write_strobe_n, read_output_enable_n} === 2'b11, "strobes not idle");
        chk({low_byte_enable_pin_n, mem_data_oe} === 2'b10, "enables not idle");
    endtask

    task automatic t_data16();
        acc(EMC_SP_DATA, 1'b1, 22'h000100, 2'h3, 16'hA5C3, 14, 1'b0, 16'h0000);
        acc(EMC_SP_DATA, 1'b1, 22'h000100, 2'h1, 16'h0011, 14, 1'b0, 16'h0000);
        acc(EMC_SP_DATA, 1'b0, 22'h000100, 2'h3, 16'h0000, 14, 1'b0, 16'hA511);
    endtask

    task automatic t_slow();
        fast_rate = 1'b0;
        acc(EMC_SP_DATA, 1'b0, 22'h000100, 2'h3, 16'h0000, 38, 1'b0, 16'hA511);
        fast_rate = 1'b1;
    endtask

    // a word on an 8-bit space is two bus cycles, the second 13 cycles after the first
    task automatic t_code8();
        acc(EMC_SP_CODE_AS_DATA, 1'b1, 22'h002000, 2'h3, 16'h1234, 27, 1'b0, 16'h0000);
        acc(EMC_SP_CODE_AS_DATA, 1'b1, 22'h002000, 2'h2, 16'hEE00, 14, 1'b0, 16'h0000);
        acc(EMC_SP_CODE, 1'b0, 22'h002000, 2'h3, 16'h0000, 27, 1'b0, 16'hEE34);
        acc(EMC_SP_CODE_AS_DATA, 1'b0, 22'h002000, 2'h3, 16'h0000, 27, 1'b0, 16'hEE34);
        acc(EMC_SP_CODE_AS_DATA, 1'b0, 22'h000FFE, 2'h3, 16'h0000, 1, 1'b1, 16'h0000);
        // code space rebuilt as a single x16 part
        {code_wide16, code_single16} = 2'b11;
        acc(EMC_SP_CODE_AS_DATA, 1'b1, 22'h004000, 2'h3, 16'h5AA5, 14, 1'b0, 16'h0000);
        acc(EMC_SP_CODE, 1'b0, 22'h004000, 2'h3, 16'h0000, 14, 1'b0, 16'h5AA5);
        {code_wide16, code_single16} = 2'b00;
    endtask

    task automatic t_overlay();
        overlay_en = 8'h80;
        data_top_sec = 8'hFF;
        acc(EMC_SP_DATA, 1'b1, 22'h3FC010, 2'h3, 16'hBEEF, 14, 1'b0, 16'h0000);
        acc(EMC_SP_CODE, 1'b0, 22'h01C010, 2'h3, 16'h0000, 14, 1'b0, 16'hBEEF);
        overlay_en = 8'h00;
        acc(EMC_SP_CODE, 1'b0, 22'h01C010, 2'h3, 16'h0000, 27, 1'b0, 16'h0000);
    endtask

    // second reset with strap low turns data space into two x8 parts
    task automatic t_two_x8();
        do_reset(1'b0);
        acc(EMC_SP_DATA, 1'b1, 22'h000200, 2'h3, 16'hA5C3, 14, 1'b0, 16'h0000);
        acc(EMC_SP_DATA, 1'b1, 22'h000200, 2'h2, 16'h7700, 14, 1'b0, 16'h0000);
        acc(EMC_SP_DATA, 1'b0, 22'h000200, 2'h3, 16'h0000, 14, 1'b0, 16'h77C3);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        n_fail = 0;
        num_checks = 0;
        {req, req_we, req_addr, req_be, req_wdata} = '0;
        req_space = EMC_SP_CODE;
        {code_wide16, code_single16, data_wide16, fast_rate} = 4'b0011;
        overlay_en = 8'h00;
        data_top_sec = 8'hFF;
        do_reset(1'b1);
        t_idle();
        t_data16();
        t_slow();
        t_code8();
        t_overlay();
        t_two_x8();
        t_idle();
        tally_and_finish();
    end
endmodule // testbench
